// [verilog/sfs_pkg.sv]
`default_nettype none
package sfs_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  // Control field positions
  localparam int GEN_RST_BIT  = 0;
  localparam int FS_RST_BIT   = 1;
  localparam int TX_INTM_LSB  = 2;
  localparam int RX_INTM_LSB  = 4;
  // Status field positions
  localparam int TX_EMPTY_N_BIT = 0;
  localparam int TX_ACTIVE_BIT  = 1;
  localparam int FS_RUN_BIT     = 2;
  // Widths and encodings
  localparam int PERIOD_W = 12;
  localparam int WORD_BITS = 16;
  localparam int BITCNT_W = 5;
  localparam logic [1:0] INTM_END_OF_BLOCK = 2'h1;
  localparam logic [1:0] INTM_RESET        = 2'h0;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 12'h000;
  // Sample-rate clock ticks from frame-sync release to first frame sync
  localparam int FIRST_FS_TICKS = 8;
  localparam logic [PERIOD_W-1:0] FIRST_FS_LOAD = PERIOD_W'(FIRST_FS_TICKS - 1);
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  typedef enum logic {TX_IDLE, TX_SHIFT} sfs_tx_state_t;
endpackage
`default_nettype wire

// [verilog/sfs_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module sfs_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Asynchronous level in, filtered level out
  input  wire logic async_in,
  output var  logic level_out
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  logic level_nxt;

  // Output follows only once the last two stages agree
  assign level_nxt = (ff2_r == ff3_r) ? ff3_r : level_out;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ff1_r     <= 1'b0;
      ff2_r     <= 1'b0;
      ff3_r     <= 1'b0;
      level_out <= 1'b0;
    end else begin
      ff1_r     <= async_in;
      ff2_r     <= ff1_r;
      ff3_r     <= ff2_r;
      level_out <= level_nxt;
    end
  end
endmodule // sfs_sync
`default_nettype wire

// [verilog/sfs_ctrl.sv]
// Functional notes
// - Frame-sync release gives its first frame sync after exactly 8 sample-rate ticks.
// - Setting frame-sync reset while generator is held in reset is ignored.
// - Clearing generator reset while frame sync runs drops frame sync first.
// - End-of-block mode raises new-block event at each frame end too.
// - Late holding-register write near word end is kept; empty flag never sticks.
`timescale 1ns/1ns
`default_nettype none
module sfs_ctrl (
  // System
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic        HREADYOUT,
  output var  logic [31:0] HRDATA,
  output var  logic        HRESP,
  // Serial link
  input  wire logic        SAMPLE_RATE_CLOCK,
  output var  logic        FRAME_SYNC_OUT,
  output var  logic        SERIAL_DATA_OUT,
  output var  logic        NEW_BLOCK_PULSE,
  output var  logic        TRANSMIT_SHIFT_EMPTY_N
);
  logic                          srclk_lvl;
  logic                          srclk_prev_r;
  logic                          gen_rst_n_r;
  logic                          fs_rst_n_r;
  logic                          gen_off_pend_r;
  logic [1:0]                    tx_intm_r;
  logic [1:0]                    rx_intm_r;
  logic [sfs_pkg::PERIOD_W-1:0]  period_r;
  logic [sfs_pkg::PERIOD_W-1:0]  fs_cnt_r;
  logic [sfs_pkg::WORD_BITS-1:0] thr_r;
  logic                          thr_full_r;
  logic [sfs_pkg::WORD_BITS-1:0] shift_r;
  logic [sfs_pkg::BITCNT_W-1:0]  bit_cnt_r;
  sfs_pkg::sfs_tx_state_t        tx_state_r;
  logic                          dph_wr_r;
  logic [7:0]                    dph_addr_r;

  sfs_sync u_srclk_sync (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .async_in  (SAMPLE_RATE_CLOCK),
    .level_out (srclk_lvl)
  );

  // Bus decode
  wire        acc      = HSEL & HREADY & (HTRANS == sfs_pkg::HTRANS_NONSEQ);
  wire        wr_ctrl  = dph_wr_r & (dph_addr_r == sfs_pkg::CTRL_OFS);
  wire        wr_per   = dph_wr_r & (dph_addr_r == sfs_pkg::PERIOD_OFS);
  wire        wr_thr   = dph_wr_r & (dph_addr_r == sfs_pkg::TXDATA_OFS);
  wire [7:0]  a_ofs    = {HADDR[7:2], 2'h0};
  wire        a_hit    = (HADDR[31:8] == 24'h000000);
  wire        w_gen    = HWDATA[sfs_pkg::GEN_RST_BIT];
  wire        w_fs     = HWDATA[sfs_pkg::FS_RST_BIT];

  // Sample-rate tick: rising edge of the filtered link clock, only out of reset
  wire        sr_edge  = srclk_lvl & ~srclk_prev_r;
  wire        tick     = sr_edge & gen_rst_n_r;
  wire        fs_run   = gen_rst_n_r & fs_rst_n_r;
  wire        fs_evt   = tick & fs_run & (fs_cnt_r == '0);
  wire        word_end = (tx_state_r == sfs_pkg::TX_SHIFT) & tick & (bit_cnt_r == '0);
  wire        tx_load  = fs_evt & thr_full_r;
  wire        eob_mode = (tx_intm_r == sfs_pkg::INTM_END_OF_BLOCK)
                       | (rx_intm_r == sfs_pkg::INTM_END_OF_BLOCK);

  // Control register next values
  // Stopping the generator while frame sync runs: drop frame sync now,
  // generator one cycle later, so no half frame escapes
  wire        stop_req  = wr_ctrl & ~w_gen & fs_rst_n_r;
  wire        gen_nxt   = gen_off_pend_r ? 1'b0 :
                          wr_ctrl ? (w_gen | stop_req) : gen_rst_n_r;
  // A set during the shutdown cycle would outlive the generator
  wire        fs_nxt    = wr_ctrl ? (w_fs & w_gen & gen_rst_n_r & ~gen_off_pend_r)
                                  : fs_rst_n_r;
  wire [sfs_pkg::PERIOD_W-1:0] cnt_nxt =
      ~fs_run ? sfs_pkg::FIRST_FS_LOAD :
      (tick ? ((fs_cnt_r == '0) ? period_r : fs_cnt_r - 1'b1)
            : fs_cnt_r);
  // Write that lands with the load still counts
  wire        thr_full_nxt = wr_thr | (thr_full_r & ~tx_load);

  wire [31:0] ctrl_rd = {26'h0, rx_intm_r, tx_intm_r, fs_rst_n_r, gen_rst_n_r};
  wire [31:0] stat_rd = {29'h0, fs_run, (tx_state_r == sfs_pkg::TX_SHIFT),
                         TRANSMIT_SHIFT_EMPTY_N};
  wire [31:0] rd_mux  = ~a_hit ? 32'h0000_0000 :
                        (a_ofs == sfs_pkg::CTRL_OFS)   ? ctrl_rd :
                        (a_ofs == sfs_pkg::PERIOD_OFS) ? {20'h0, period_r} :
                        (a_ofs == sfs_pkg::STATUS_OFS) ? stat_rd : 32'h0000_0000;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      HRDATA     <= sfs_pkg::WORD_RESET;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      dph_wr_r   <= acc & HWRITE & a_hit;
      dph_addr_r <= a_ofs;
      if (acc && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      gen_rst_n_r    <= 1'b0;
      fs_rst_n_r     <= 1'b0;
      gen_off_pend_r <= 1'b0;
      tx_intm_r      <= sfs_pkg::INTM_RESET;
      rx_intm_r      <= sfs_pkg::INTM_RESET;
      period_r       <= sfs_pkg::PERIOD_RESET;
      fs_cnt_r       <= sfs_pkg::FIRST_FS_LOAD;
      srclk_prev_r   <= 1'b0;
    end else begin
      gen_rst_n_r    <= gen_nxt;
      fs_rst_n_r     <= fs_nxt;
      gen_off_pend_r <= stop_req;
      fs_cnt_r       <= cnt_nxt;
      srclk_prev_r   <= srclk_lvl;
      if (wr_ctrl) begin
        tx_intm_r <= HWDATA[sfs_pkg::TX_INTM_LSB +: 2];
        rx_intm_r <= HWDATA[sfs_pkg::RX_INTM_LSB +: 2];
      end
      if (wr_per) begin
        period_r <= HWDATA[sfs_pkg::PERIOD_W-1:0];
      end
    end
  end

  // Transmit path: holding register feeds shifter at each frame sync while it holds a word
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      thr_r      <= '0;
      thr_full_r <= 1'b0;
      shift_r    <= '0;
      bit_cnt_r  <= '0;
      tx_state_r <= sfs_pkg::TX_IDLE;
    end else begin
      thr_full_r <= thr_full_nxt;
      if (wr_thr) begin
        thr_r <= HWDATA[sfs_pkg::WORD_BITS-1:0];
      end
      if (tx_load) begin
        shift_r    <= thr_r;
        bit_cnt_r  <= sfs_pkg::BITCNT_W'(sfs_pkg::WORD_BITS - 1);
        tx_state_r <= sfs_pkg::TX_SHIFT;
      end else begin
        case (tx_state_r)
          sfs_pkg::TX_SHIFT: begin
            if (!gen_rst_n_r || word_end) begin
              tx_state_r <= sfs_pkg::TX_IDLE;
            end else if (tick) begin
              shift_r   <= {shift_r[sfs_pkg::WORD_BITS-2:0], 1'b0};
              bit_cnt_r <= bit_cnt_r - 1'b1;
            end
          end
          default: tx_state_r <= sfs_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // Link outputs, all registered
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      FRAME_SYNC_OUT         <= 1'b0;
      SERIAL_DATA_OUT        <= 1'b0;
      NEW_BLOCK_PULSE        <= 1'b0;
      TRANSMIT_SHIFT_EMPTY_N <= 1'b0;
    end else begin
      // Frame sync held for one sample-rate period
      if (fs_evt) begin
        FRAME_SYNC_OUT <= 1'b1;
      end else if (tick || !fs_run) begin
        FRAME_SYNC_OUT <= 1'b0;
      end
      SERIAL_DATA_OUT <= tx_load ? thr_r[sfs_pkg::WORD_BITS-1]
                       : (tx_state_r == sfs_pkg::TX_SHIFT) ? shift_r[sfs_pkg::WORD_BITS-1]
                       : 1'b0;
      // Frame end coincides with the next frame sync, so block 0 is announced too
      NEW_BLOCK_PULSE <= fs_evt & eob_mode;
      // Low only when nothing is held and nothing is shifting
      TRANSMIT_SHIFT_EMPTY_N <= thr_full_nxt | tx_load
                              | ((tx_state_r == sfs_pkg::TX_SHIFT) & ~word_end
                                 & gen_rst_n_r);
    end
  end

  // Checks
  logic [3:0] ticks_since_r;
  logic       first_pend_r;
  logic       fs_run_prev_r;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ticks_since_r <= 4'h0;
      first_pend_r  <= 1'b0;
      fs_run_prev_r <= 1'b0;
    end else begin
      fs_run_prev_r <= fs_run;
      first_pend_r  <= fs_run & (first_pend_r | ~fs_run_prev_r) & ~fs_evt;
      ticks_since_r <= ~fs_run ? 4'h0 : (tick & (ticks_since_r != 4'hF))
                       ? ticks_since_r + 4'h1 : ticks_since_r;
    end
  end

  first_fs_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fs_evt && first_pend_r |-> ticks_since_r == 4'h7)
    else $error("first frame sync not after 8 ticks");
  fs_ignore_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !gen_rst_n_r |-> ##1 !fs_rst_n_r)
    else $error("frame sync reset set while generator held");
  stop_order_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fs_run && wr_ctrl && !w_gen |=> !fs_rst_n_r && gen_rst_n_r ##1 !gen_rst_n_r)
    else $error("generator stopped before frame sync");
  new_block_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fs_evt && eob_mode |=> NEW_BLOCK_PULSE && FRAME_SYNC_OUT)
    else $error("missing new block event at frame end");
  late_write_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_thr |=> thr_full_r && TRANSMIT_SHIFT_EMPTY_N)
    else $error("late holding write lost or empty flag stuck");
  empty_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    word_end && thr_full_r |-> TRANSMIT_SHIFT_EMPTY_N ##1 TRANSMIT_SHIFT_EMPTY_N)
    else $error("empty flag dropped with a word still held");
  fs_period_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fs_evt |=> fs_cnt_r == $past(period_r))
    else $error("frame period reload wrong");
endmodule // sfs_ctrl
`default_nettype wire

// [bench/sfs_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module sfs_partner (
  // Link
  output var  logic        sample_rate_clock,
  input  wire logic        frame_sync,
  input  wire logic        serial_data,
  // Observation
  input  wire logic        clr,
  output var  int          first_edge,
  output var  int          gap,
  output var  int          frames,
  output var  logic [15:0] word
);
  int          edges;
  int          last_fs;
  int          bit_left;
  logic [15:0] shreg;
  initial sample_rate_clock = 1'b0;
  // Runs free: the generator counts ticks between frames too
  always #80 sample_rate_clock = ~sample_rate_clock;
  always @(posedge sample_rate_clock or posedge clr) begin
    if (clr) begin
      edges <= 0;
      first_edge <= 0;
      frames <= 0;
      last_fs <= 0;
      bit_left <= 0;
    end else begin
      edges <= edges + 1;
      if (frame_sync === 1'b1) begin
        frames <= frames + 1;
        if (first_edge == 0) first_edge <= edges + 1;
        gap <= edges + 1 - last_fs;
        last_fs <= edges + 1;
        shreg <= {15'h0, serial_data};
        bit_left <= 15;
      end else if (bit_left > 0) begin
        shreg <= {shreg[14:0], serial_data};
        bit_left <= bit_left - 1;
        if (bit_left == 1) word <= {shreg[14:0], serial_data};
      end
    end
  end
endmodule // sfs_partner
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        SYS_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic        clr = 1'b0;
  wire logic   HREADYOUT, HRESP, FS, SDO, NBP, EMPTY_N, SRC;
  wire logic [31:0] HRDATA;
  int          errors = 0;
  int          tests_run = 0;
  int          pulses = 0;
  int          first_edge, gap, frames, p0, f0;
  logic [15:0] word;
  logic [31:0] rdv;
  logic [31:0] modes [2] = '{32'h13, 32'h03};

  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (NBP === 1'b1) pulses <= pulses + 1;

  sfs_ctrl i_sfs_ctrl (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .SAMPLE_RATE_CLOCK(SRC),
    .FRAME_SYNC_OUT(FS), .SERIAL_DATA_OUT(SDO), .NEW_BLOCK_PULSE(NBP),
    .TRANSMIT_SHIFT_EMPTY_N(EMPTY_N));
  sfs_partner i_sfs_partner (.sample_rate_clock(SRC), .frame_sync(FS), .serial_data(SDO),
    .clr(clr), .first_edge(first_edge), .gap(gap), .frames(frames), .word(word));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= sfs_pkg::HTRANS_NONSEQ;
    HWRITE <= wr;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rdv = HRDATA;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdv, exp);
    check({31'h0, HRESP}, 32'h0);
  endtask

  // Lands bus traffic well clear of the tick synchroniser window
  task automatic sync_link;
    @(posedge SRC);
    repeat (6) @(posedge SYS_CLK);
  endtask

  task automatic end_sim;
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    rd(sfs_pkg::STATUS_OFS, 32'h0);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    bus(1'b1, sfs_pkg::CTRL_OFS, 32'h2);
    rd(sfs_pkg::CTRL_OFS, 32'h0);
    bus(1'b1, sfs_pkg::CTRL_OFS, 32'h3);
    rd(sfs_pkg::CTRL_OFS, 32'h1);
    bus(1'b1, sfs_pkg::PERIOD_OFS, 32'h13);
    bus(1'b1, sfs_pkg::TXDATA_OFS, 32'hA5C3);
    rd(sfs_pkg::STATUS_OFS, 32'h1);
    sync_link;
    clr <= 1'b1;
    pulses <= 0;
    bus(1'b1, sfs_pkg::CTRL_OFS, 32'h7);
    clr <= 1'b0;
    wait (frames >= 2);
    check(32'(first_edge), 32'(sfs_pkg::FIRST_FS_TICKS + 1));
    check({16'h0, word}, 32'hA5C3);
    // Queued for frame 3, so a word is shifting when the late write lands
    @(posedge SYS_CLK);
    bus(1'b1, sfs_pkg::TXDATA_OFS, 32'h5AA5);
    wait (frames >= 3);
    check(32'(gap), 32'h14);
    check(32'(pulses), 32'h3);
    // Lands the write on the last bit of the frame-3 word
    repeat (13) @(posedge SRC);
    sync_link;
    bus(1'b1, sfs_pkg::TXDATA_OFS, 32'h3C5A);
    wait (frames >= 4);
    check({16'h0, word}, 32'h5AA5);
    check({31'h0, EMPTY_N}, 32'h1);
    @(posedge SYS_CLK);
    rd(sfs_pkg::STATUS_OFS, 32'h7);
    wait (frames >= 5);
    check({16'h0, word}, 32'h3C5A);
    check({31'h0, EMPTY_N}, 32'h0);
    foreach (modes[i]) begin
      @(posedge SYS_CLK);
      bus(1'b1, sfs_pkg::CTRL_OFS, modes[i]);
      f0 = frames;
      wait (frames == f0 + 1);
      p0 = pulses;
      wait (frames == f0 + 3);
      check(32'(pulses - p0), (i == 0) ? 32'h2 : 32'h0);
    end
    @(posedge SYS_CLK);
    bus(1'b1, sfs_pkg::CTRL_OFS, 32'h2);
    // Frame sync drops first, the generator one cycle later
    rd(sfs_pkg::CTRL_OFS, 32'h1);
    rd(sfs_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(posedge SRC);
    f0 = frames;
    repeat (30) @(posedge SRC);
    check(32'(frames), 32'(f0));
    end_sim;
  end
endmodule // tb
`default_nettype wire
